//--- core/rgs_top.sv
// rgmii skew registers, delay loops, in-band status and idle signalling
`timescale 1ns/1ps
`default_nettype none
module rgs_top #(
  parameter int TAP_W    = 6,
  parameter int RXC_HALF = rgs_pkg::RXC_HALF_CYC
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  input  wire logic [4:0]       reg_addr,
  input  wire logic [15:0]      reg_wdata,
  output logic      [15:0]      reg_rdata,
  output logic                  reg_rvalid,
  input  wire logic             txc,
  input  wire logic             tx_ctl,
  input  wire logic [3:0]       txd,
  output logic                  tx_lpi,
  output logic                  rxc,
  output logic                  rx_ctl,
  output logic      [3:0]       rxd,
  input  wire logic             rx_dv,
  input  wire logic             rx_er,
  input  wire logic [7:0]       rx_byte,
  input  wire logic             rx_lpi_req,
  input  wire logic             link_up,
  input  wire logic             duplex_full,
  input  wire logic [1:0]       speed,
  input  wire logic [TAP_W-1:0] rx_cal_tap,
  input  wire logic [TAP_W-1:0] tx_cal_tap,
  output logic      [TAP_W-1:0] rx_tap,
  output logic      [TAP_W-1:0] tx_tap,
  output logic                  rx_bypassed,
  output logic                  tx_bypassed,
  output logic      [15:0]      ctl_pad_skew,
  output logic      [15:0]      rxd_pad_skew,
  output logic      [15:0]      txd_pad_skew,
  output logic      [15:0]      clk_pad_skew
);
  // ==========================================================
  // elaboration checks
  if (TAP_W < 4 || TAP_W > 8) begin : g_bad_tap
    $error("TAP_W must be 4 to 8");
  end
  // the half-period counter is 8 bits wide
  if (RXC_HALF < 1 || RXC_HALF > 256) begin : g_bad_half
    $error("RXC_HALF must be 1 to 256");
  end

  // ==========================================================
  // register file
  logic [1:0]       ind_fn;
  logic [4:0]       ind_dev;
  logic [15:0]      ind_ix;
  logic [15:0]      dll_ctl [2];
  logic [15:0]      dll_rst;
  logic [1:0]       next_ind_fn;
  logic [4:0]       next_ind_dev;
  logic [15:0]      next_ind_ix;
  logic [15:0]      next_ctl_skew;
  logic [15:0]      next_rxd_skew;
  logic [15:0]      next_txd_skew;
  logic [15:0]      next_clk_skew;
  logic [15:0]      next_dll_ctl [2];
  logic [15:0]      next_dll_rst;
  logic [15:0]      next_rdata;
  logic [15:0]      ind_rd;
  logic             ind_hit;

  always_comb begin
    next_ind_fn   = ind_fn;
    next_ind_dev  = ind_dev;
    next_ind_ix   = ind_ix;
    next_ctl_skew = ctl_pad_skew;
    next_rxd_skew = rxd_pad_skew;
    next_txd_skew = txd_pad_skew;
    next_clk_skew = clk_pad_skew;
    next_dll_ctl  = dll_ctl;
    next_dll_rst  = dll_rst;
    ind_hit       = (ind_fn == rgs_pkg::FN_DATA) &&
                    (ind_dev == rgs_pkg::DEV_RGMII);
    // four skew registers plus loop registers
    unique case (ind_ix)
      rgs_pkg::IX_CTL_SKEW: ind_rd = ctl_pad_skew;
      rgs_pkg::IX_RXD_SKEW: ind_rd = rxd_pad_skew;
      rgs_pkg::IX_TXD_SKEW: ind_rd = txd_pad_skew;
      rgs_pkg::IX_CLK_SKEW: ind_rd = clk_pad_skew;
      rgs_pkg::IX_RX_DLL:   ind_rd = dll_ctl[0];
      rgs_pkg::IX_TX_DLL:   ind_rd = dll_ctl[1];
      rgs_pkg::IX_DLL_RST:  ind_rd = dll_rst;
      default:              ind_rd = 16'h0000;
    endcase
    if (reg_wr && reg_addr == rgs_pkg::REG_IND_CTRL) begin
      next_ind_fn  = reg_wdata[rgs_pkg::FN_HI:rgs_pkg::FN_LO];
      next_ind_dev = reg_wdata[rgs_pkg::DEV_HI:0];
    end
    if (reg_wr && reg_addr == rgs_pkg::REG_IND_DATA) begin
      if (ind_fn == rgs_pkg::FN_ADDR) begin
        next_ind_ix = reg_wdata;
      end else if (ind_hit) begin
        unique case (ind_ix)
          // pad skew codes, 4 or 5 bits
          rgs_pkg::IX_CTL_SKEW:
            next_ctl_skew = reg_wdata & rgs_pkg::MSK_CTL_SKEW;
          rgs_pkg::IX_RXD_SKEW:
            next_rxd_skew = reg_wdata & rgs_pkg::MSK_DAT_SKEW;
          rgs_pkg::IX_TXD_SKEW:
            next_txd_skew = reg_wdata & rgs_pkg::MSK_DAT_SKEW;
          // all ones gives maximum clock delay
          rgs_pkg::IX_CLK_SKEW:
            next_clk_skew = reg_wdata & rgs_pkg::MSK_CLK_SKEW;
          rgs_pkg::IX_RX_DLL:
            next_dll_ctl[0] = reg_wdata & rgs_pkg::MSK_DLL;
          rgs_pkg::IX_TX_DLL:
            next_dll_ctl[1] = reg_wdata & rgs_pkg::MSK_DLL;
          // stored as written, no self clear
          rgs_pkg::IX_DLL_RST:
            next_dll_rst = reg_wdata & rgs_pkg::MSK_DLL_RST;
          default: ;
        endcase
      end
    end
    next_rdata = 16'h0000;
    if (reg_addr == rgs_pkg::REG_IND_CTRL) begin
      next_rdata = {ind_fn, 9'h000, ind_dev};
    end else if (reg_addr == rgs_pkg::REG_IND_DATA) begin
      if (ind_fn == rgs_pkg::FN_ADDR) begin
        next_rdata = ind_ix;
      end else if (ind_hit) begin
        next_rdata = ind_rd;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ind_fn       <= rgs_pkg::FN_ADDR;
      ind_dev      <= 5'h00;
      ind_ix       <= 16'h0000;
      ctl_pad_skew <= rgs_pkg::RST_CTL_SKEW;
      rxd_pad_skew <= rgs_pkg::RST_DAT_SKEW;
      txd_pad_skew <= rgs_pkg::RST_DAT_SKEW;
      clk_pad_skew <= rgs_pkg::RST_CLK_SKEW;
      dll_ctl[0]   <= rgs_pkg::RST_RX_DLL;
      dll_ctl[1]   <= rgs_pkg::RST_TX_DLL;
      dll_rst      <= rgs_pkg::RST_DLL_RST;
      reg_rdata    <= 16'h0000;
      reg_rvalid   <= 1'b0;
    end else begin
      ind_fn       <= next_ind_fn;
      ind_dev      <= next_ind_dev;
      ind_ix       <= next_ind_ix;
      ctl_pad_skew <= next_ctl_skew;
      rxd_pad_skew <= next_rxd_skew;
      txd_pad_skew <= next_txd_skew;
      clk_pad_skew <= next_clk_skew;
      dll_ctl      <= next_dll_ctl;
      dll_rst      <= next_dll_rst;
      reg_rdata    <= reg_rd ? next_rdata : reg_rdata;
      reg_rvalid   <= reg_rd;
    end
  end

  // ==========================================================
  // delay loops, rx is index 0, tx index 1
  logic [7:0]       tune_cnt;
  logic [7:0]       next_tune_cnt;
  logic             tune_tick;
  logic [TAP_W-1:0] tap_arr [2];
  logic [TAP_W-1:0] cal_arr [2];
  logic [1:0]       byp_arr;

  // shared tuning cadence keeps both loops in step
  assign tune_tick     = (tune_cnt == 8'(rgs_pkg::TUNE_CYC - 1));
  assign next_tune_cnt = tune_tick ? 8'h00 : tune_cnt + 8'h01;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tune_cnt <= 8'h00;
    end else begin
      tune_cnt <= next_tune_cnt;
    end
  end

  assign cal_arr[0] = rx_cal_tap;
  assign cal_arr[1] = tx_cal_tap;
  for (genvar d = 0; d < 2; d++) begin : g_loop
    // each direction has its own controls
    rgs_delay_loop #(.TAP_W(TAP_W)) u_loop (
      .clk          (clk),
      .rst_n        (rst_n),
      .bypass       (dll_ctl[d][rgs_pkg::DLL_BYP_BIT]),
      .tune_disable (dll_ctl[d][rgs_pkg::DLL_TDIS_BIT]),
      .tap_adj      (dll_ctl[d][rgs_pkg::DLL_ADJ_LO +: 4]),
      .tap_sel      (dll_ctl[d][rgs_pkg::DLL_SEL_LO +: TAP_W]),
      .loop_reset   (dll_rst[d]),
      .tune_tick    (tune_tick),
      .cal_tap      (cal_arr[d]),
      .tap_out      (tap_arr[d]),
      .tuned        (),
      .bypassed     (byp_arr[d])
    );
  end
  assign rx_tap      = tap_arr[0];
  assign tx_tap      = tap_arr[1];
  assign rx_bypassed = byp_arr[0];
  assign tx_bypassed = byp_arr[1];

  // ==========================================================
  // receive side: clock divider, status, idle and data
  logic [7:0] rxc_cnt;
  logic [7:0] next_rxc_cnt;
  logic       next_rxc;
  logic       next_rx_ctl;
  logic [3:0] next_rxd;
  logic [7:0] hold_byte;
  logic [7:0] next_hold;
  logic       hold_err;
  logic       next_hold_err;
  logic       hold_dv;
  logic       next_hold_dv;
  logic [3:0] status;
  logic       wrap;

  assign status = {duplex_full, speed, link_up};
  assign wrap   = (rxc_cnt == 8'(RXC_HALF - 1));

  always_comb begin
    next_rxc_cnt  = wrap ? 8'h00 : rxc_cnt + 8'h01;
    next_rxc      = wrap ? !rxc : rxc;
    next_rx_ctl   = rx_ctl;
    next_rxd      = rxd;
    next_hold     = hold_byte;
    next_hold_err = hold_err;
    next_hold_dv  = hold_dv;
    if (wrap && !rxc) begin
      // rising half: pick frame, idle request or status
      if (rx_dv) begin
        next_hold     = rx_byte;
        next_hold_dv  = 1'b1;
        next_hold_err = rx_er;
      // idle: ctl low then high, byte 01
      end else if (rx_lpi_req) begin
        next_hold     = rgs_pkg::LPI_BYTE;
        next_hold_dv  = 1'b0;
        next_hold_err = 1'b1;
      // status in the gap unless an idle request is pending
      end else begin
        next_hold     = {status, status};
        next_hold_dv  = 1'b0;
        next_hold_err = 1'b0;
      end
      next_rx_ctl = next_hold_dv;
      next_rxd    = next_hold[3:0];
    end else if (wrap && rxc) begin
      next_rx_ctl = hold_dv ^ hold_err;
      // slow speeds keep data for the whole cycle
      if (speed == rgs_pkg::SPD_1000) begin
        next_rxd = hold_byte[7:4];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rxc_cnt   <= 8'h00;
      rxc       <= 1'b0;
      rx_ctl    <= 1'b0;
      rxd       <= 4'h0;
      hold_byte <= 8'h00;
      hold_err  <= 1'b0;
      hold_dv   <= 1'b0;
    end else begin
      rxc_cnt   <= next_rxc_cnt;
      rxc       <= next_rxc;
      rx_ctl    <= next_rx_ctl;
      rxd       <= next_rxd;
      hold_byte <= next_hold;
      hold_err  <= next_hold_err;
      hold_dv   <= next_hold_dv;
    end
  end

  // ==========================================================
  // transmit side: sample link clock, detect idle request
  logic [5:0] tx_s1;
  logic [5:0] tx_s2;
  logic       txc_d;
  logic       rise_ctl;
  logic [3:0] rise_d;
  logic       next_rise_ctl;
  logic [3:0] next_rise_d;
  logic       next_tx_lpi;
  logic       t_rise;
  logic       t_fall;

  // first stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_s1 <= 6'h00;
      tx_s2 <= 6'h00;
      txc_d <= 1'b0;
    end else begin
      tx_s1 <= {txc, tx_ctl, txd};
      tx_s2 <= tx_s1;
      txc_d <= tx_s2[5];
    end
  end

  assign t_rise = tx_s2[5] && !txc_d;
  assign t_fall = !tx_s2[5] && txc_d;

  always_comb begin
    next_rise_ctl = t_rise ? tx_s2[4] : rise_ctl;
    next_rise_d   = t_rise ? tx_s2[3:0] : rise_d;
    next_tx_lpi   = tx_lpi;
    if (t_fall) begin
      if (speed == rgs_pkg::SPD_1000) begin
        next_tx_lpi = !rise_ctl && tx_s2[4] &&
                      ({tx_s2[3:0], rise_d} == rgs_pkg::LPI_BYTE);
      end else begin
        next_tx_lpi = !rise_ctl && tx_s2[4] &&
                      (rise_d == rgs_pkg::LPI_BYTE[3:0]);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rise_ctl <= 1'b0;
      rise_d   <= 4'h0;
      tx_lpi   <= 1'b0;
    end else begin
      rise_ctl <= next_rise_ctl;
      rise_d   <= next_rise_d;
      tx_lpi   <= next_tx_lpi;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_rise_idle;
    wrap && !rxc && !rx_dv && !rx_lpi_req;
  endsequence
  sequence s_rise_lpi;
    wrap && !rxc && !rx_dv && rx_lpi_req;
  endsequence

  status_in_gap_a: assert property (
    s_rise_idle |=> !rx_ctl && (rxd == $past(status)))
    else $error("idle gap did not carry status");
  lpi_rise_half_a: assert property (
    s_rise_lpi |=> !rx_ctl && (rxd == 4'h1))
    else $error("receive idle first half wrong");
  lpi_fall_half_a: assert property (
    s_rise_lpi ##RXC_HALF 1 |=> rx_ctl &&
      (rxd == (($past(speed) == rgs_pkg::SPD_1000) ? 4'h0 : 4'h1)))
    else $error("receive idle second half wrong");
  rxc_half_period_a: assert property (
    $rose(rxc) |-> rxc[*4])
    else $error("receive clock half period wrong");
  clk_skew_max_a: assert property (
    reg_wr && reg_addr == 5'h0e && ind_hit && ind_ix == 16'h0008 &&
      reg_wdata == 16'h03ff |=> clk_pad_skew == 16'h03ff)
    else $error("clock skew write lost");
  loop_reset_hold_a: assert property (
    !(reg_wr && reg_addr == 5'h0e) |=> $stable(dll_rst))
    else $error("loop reset bits changed on their own");
  bypass_per_dir_a: assert property (
    ##1 (dll_ctl[1][14] != dll_ctl[0][14]) |=>
      (tx_bypassed != rx_bypassed))
    else $error("bypass bits not independent");
  tx_lpi_seen_a: assert property (
    t_fall && speed == 2'h2 && !rise_ctl && tx_s2[4] &&
      tx_s2[3:0] == 4'h0 && rise_d == 4'h1 |=> tx_lpi)
    else $error("transmit idle request missed");
endmodule // rgs_top
`default_nettype wire

//--- core/rgs_pkg.sv
// constants for the rgmii clock skew, delay loop and in-band status block
// Function
// - rx delay loop on, tx bypassed after reset
// - bypass routes input clock through one mux
// - separate bypass bit per direction
// - tuning mode recomputes tap continuously
// - tap adjust offsets mux, larger means less
// - tap select used before first tuning cycle
// - tune disable holds tap select, ignores adjust
// - loop reset bits hold value, never self-clear
// - 4-bit pin skews, 5-bit clock skews
// - skew delay rises monotonically with code
// - skew fields reset to mid code 0111
// - four skew registers: ctl, rxd, txd, clocks
// - clock skew at index 8, device 2
// - in-band status sent in idle gap unless receive idle requested
// - status nibble: duplex, speed, link
// - receive idle signalled as ctl 0/1, byte 01
// - transmit idle ctl 0/1, byte 01 recognised
// - default 2ns delay on rx clock only
// - 10/100 data rising only, ctl both edges
package rgs_pkg;
  // ==========================================================
  // direct register addresses and indirect access fields
  localparam logic [4:0]  REG_IND_CTRL  = 5'h0d;
  localparam logic [4:0]  REG_IND_DATA  = 5'h0e;
  localparam int          FN_HI         = 15;
  localparam int          FN_LO         = 14;
  localparam int          DEV_HI        = 4;
  localparam logic [1:0]  FN_ADDR       = 2'h0;
  localparam logic [1:0]  FN_DATA       = 2'h1;
  localparam logic [4:0]  DEV_RGMII     = 5'h02;
  // ==========================================================
  // indirect register indexes
  localparam logic [15:0] IX_CTL_SKEW   = 16'h0004;
  localparam logic [15:0] IX_RXD_SKEW   = 16'h0005;
  localparam logic [15:0] IX_TXD_SKEW   = 16'h0006;
  localparam logic [15:0] IX_CLK_SKEW   = 16'h0008;
  localparam logic [15:0] IX_RX_DLL     = 16'h004c;
  localparam logic [15:0] IX_TX_DLL     = 16'h004d;
  localparam logic [15:0] IX_DLL_RST    = 16'h004e;
  // ==========================================================
  // reset values and writable masks
  localparam logic [15:0] RST_CTL_SKEW  = 16'h0077;
  localparam logic [15:0] RST_DAT_SKEW  = 16'h7777;
  localparam logic [15:0] RST_CLK_SKEW  = 16'h00e7;
  localparam logic [15:0] RST_RX_DLL    = 16'h0020;
  localparam logic [15:0] RST_TX_DLL    = 16'h4020;
  localparam logic [15:0] RST_DLL_RST   = 16'h0000;
  localparam logic [15:0] MSK_CTL_SKEW  = 16'h00ff;
  localparam logic [15:0] MSK_DAT_SKEW  = 16'hffff;
  localparam logic [15:0] MSK_CLK_SKEW  = 16'h03ff;
  localparam logic [15:0] MSK_DLL       = 16'h6f3f;
  localparam logic [15:0] MSK_DLL_RST   = 16'h0003;
  // ==========================================================
  // field positions
  localparam int          DLL_BYP_BIT   = 14;
  localparam int          DLL_TDIS_BIT  = 13;
  localparam int          DLL_ADJ_LO    = 8;
  localparam int          DLL_ADJ_W     = 4;
  localparam int          DLL_SEL_LO    = 0;
  localparam int          RST_RX_BIT    = 0;
  localparam int          RST_TX_BIT    = 1;
  localparam int          SKEW4_W       = 4;
  localparam int          SKEW5_W       = 5;
  localparam int          CLK_RX_LO     = 0;
  localparam int          CLK_TX_LO     = 5;
  localparam int          CTL_TX_LO     = 0;
  localparam int          CTL_RX_LO     = 4;
  // ==========================================================
  // in-band status and idle encodings
  localparam logic [1:0]  SPD_10        = 2'h0;
  localparam logic [1:0]  SPD_100       = 2'h1;
  localparam logic [1:0]  SPD_1000      = 2'h2;
  localparam logic [7:0]  LPI_BYTE      = 8'h01;
  // ==========================================================
  // timing
  localparam int          CLK_MHZ       = 25;
  localparam int          DLL_DELAY_PS  = 2000;
  localparam int          TUNE_NS       = 1000;
  localparam int          TUNE_CYC      = (TUNE_NS * CLK_MHZ) / 1000;
  localparam int          RXC_HALF_CYC  = 4;
endpackage : rgs_pkg

//--- core/rgs_delay_loop.sv
// one clock delay loop: bypass, tuning and fixed tap selection
`timescale 1ns/1ps
`default_nettype none
module rgs_delay_loop #(
  parameter int TAP_W = 6
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             bypass,
  input  wire logic             tune_disable,
  input  wire logic [3:0]       tap_adj,
  input  wire logic [TAP_W-1:0] tap_sel,
  input  wire logic             loop_reset,
  input  wire logic             tune_tick,
  input  wire logic [TAP_W-1:0] cal_tap,
  output logic      [TAP_W-1:0] tap_out,
  output logic                  tuned,
  output logic                  bypassed
);
  logic [TAP_W-1:0] cur;
  logic [TAP_W-1:0] next_cur;
  logic [TAP_W-1:0] next_tap_out;
  logic             next_tuned;
  logic [TAP_W-1:0] base;
  logic [TAP_W-1:0] adj_w;

  // ==========================================================
  // tuning state and output tap
  always_comb begin
    next_cur     = cur;
    next_tuned   = tuned;
    adj_w        = TAP_W'(tap_adj);
    if (loop_reset) begin
      next_cur   = tap_sel;
      next_tuned = 1'b0;
    end else if (!tune_disable && !bypass && tune_tick) begin
      if (cur < cal_tap) begin
        next_cur = cur + 1'b1;
      end else if (cur > cal_tap) begin
        next_cur = cur - 1'b1;
      end
      next_tuned = 1'b1;
    end
    // tap select until first tune done
    base = tuned ? cur : tap_sel;
    if (bypass) begin
      next_tap_out = '0;
    end else if (tune_disable) begin
      next_tap_out = tap_sel;
    end else if (base > adj_w) begin
      next_tap_out = base - adj_w;
    end else begin
      next_tap_out = '0;
    end
  end

  // registers only
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cur      <= '0;
      tuned    <= 1'b0;
      tap_out  <= '0;
      bypassed <= 1'b0;
    end else begin
      cur      <= next_cur;
      tuned    <= next_tuned;
      tap_out  <= next_tap_out;
      bypassed <= bypass;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  bypass_zero_tap_a: assert property (
    bypass |=> (tap_out == '0) && bypassed)
    else $error("bypassed loop still selects a tap");
  fixed_tap_hold_a: assert property (
    (tune_disable && !bypass) |=> (tap_out == $past(tap_sel)))
    else $error("tune disable did not hold tap select");
  reset_untuned_a: assert property (
    loop_reset ##1 (!loop_reset && !tune_tick)[*2]
      |-> !tuned && (cur == $past(tap_sel, 2)))
    else $error("loop reset did not restore tap select");
endmodule // rgs_delay_loop
`default_nettype wire

//--- testbench/rgs_mac_model.sv
// mac-side partner: drives the transmit link, captures the receive link
`timescale 1ns/1ps
`default_nettype none
module rgs_mac_model (
  output logic            txc,
  output logic            tx_ctl,
  output logic      [3:0] txd,
  input  wire logic       rxc,
  input  wire logic       rx_ctl,
  input  wire logic [3:0] rxd,
  output logic      [1:0] cap_ctl,
  output logic      [7:0] cap_d
);
  // ====================
  // transmit side
  // link clock stands still low between cycles
  initial begin
    txc = 1'b0;
    tx_ctl = 1'b0;
    txd = 4'h0;
  end

  // one 400 ns txc cycle, ctl/data per half
  // lines show the inverse once hold has run out, not a stale value
  task automatic send(input logic c0, input logic [3:0] d0,
                      input logic c1, input logic [3:0] d1);
    begin
      tx_ctl = c0;
      txd = d0;
      #80 txc = 1'b1;
      #80 tx_ctl = c1;
      txd = d1;
      #80 txc = 1'b0;
      #160 tx_ctl = ~c1;
      txd = ~d1;
    end
  endtask

  // ====================
  // receive side
  // sample 2 ns late, as the delayed rx clock would
  always @(posedge rxc) begin
    #2 cap_ctl[0] = rx_ctl;
    cap_d[3:0] = rxd;
  end
  // second half: ctl always, data meaningful at 1000 only
  always @(negedge rxc) begin
    #2 cap_ctl[1] = rx_ctl;
    cap_d[7:4] = rxd;
  end
endmodule // rgs_mac_model
`default_nettype wire

//--- testbench/tb.sv
// self-checking bench for the rgmii skew, loop and status block
`timescale 1ns/1ps
`default_nettype none
module tb;
  typedef struct packed {logic [15:0] ix, pv, wd, ex;} rgs_reg_s;
  typedef struct packed {
    logic dv, lp, lk, dx; logic [1:0] sp; logic [7:0] b; logic [15:0] e;
  } rgs_rx_s;
  logic        clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [4:0]  reg_addr = 5'h00;
  logic [15:0] reg_wdata = 16'h0000, q, reg_rdata;
  logic        rx_dv = 1'b0, rx_lpi_req = 1'b0, link_up = 1'b0;
  logic        duplex_full = 1'b0, reg_rvalid, tx_lpi, rxc, rx_ctl;
  logic [1:0]  speed = 2'h0, cap_ctl;
  logic [7:0]  rx_byte = 8'h00, cap_d;
  logic [5:0]  rx_cal_tap = 6'h00, rx_tap, tx_tap;
  logic        txc, tx_ctl, rx_bypassed, tx_bypassed;
  logic [3:0]  txd, rxd;
  logic [15:0] ctl_pad_skew, rxd_pad_skew, txd_pad_skew, clk_pad_skew;
  int          num_errors = 0, checks = 0;
  // previous value, written value, value read back
  rgs_reg_s rows[9] = '{
    '{rgs_pkg::IX_CTL_SKEW, 'h0077, 'hffff, 'h00ff},
    '{rgs_pkg::IX_RXD_SKEW, 'h7777, 'h1234, 'h1234},
    '{rgs_pkg::IX_TXD_SKEW, 'h7777, 'habcd, 'habcd},
    '{rgs_pkg::IX_CLK_SKEW, 'h00e7, 'h03ff, 'h03ff},
    '{rgs_pkg::IX_CLK_SKEW, 'h03ff, 'hfc00, 'h0000},
    '{rgs_pkg::IX_RX_DLL, 'h0020, 'hffff, 'h6f3f},
    '{rgs_pkg::IX_TX_DLL, 'h4020, 'h0020, 'h0020},
    '{rgs_pkg::IX_DLL_RST, 'h0000, 'h0003, 'h0003},
    '{rgs_pkg::IX_DLL_RST, 'h0003, 'h0000, 'h0000}};
  // captured {ctl fall, ctl rise, data fall, data rise}
  rgs_rx_s rxr[8] = '{'{0, 0, 1, 1, 0, 0, 'h0099}, '{0, 0, 0, 0, 1, 0, 'h0022},
    '{0, 0, 1, 0, 2, 0, 'h0055}, '{0, 0, 1, 1, 2, 0, 'h00dd},
    '{0, 1, 1, 1, 2, 0, 'h0201}, '{0, 1, 1, 1, 1, 0, 'h0211},
    '{1, 0, 1, 1, 2, 'h5a, 'h035a}, '{1, 1, 1, 1, 1, 'h5a, 'h03aa}};

  // ====================
  // clock, design and partner
  always #20 clk = ~clk;
  rgs_top #(.TAP_W(6)) u_dut (.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .txc(txc),
    .tx_ctl(tx_ctl), .txd(txd), .tx_lpi(tx_lpi), .rxc(rxc), .rx_ctl(rx_ctl),
    .rxd(rxd), .rx_dv(rx_dv), .rx_er(1'b0), .rx_byte(rx_byte),
    .rx_lpi_req(rx_lpi_req), .link_up(link_up), .duplex_full(duplex_full),
    .speed(speed), .rx_cal_tap(rx_cal_tap), .tx_cal_tap(6'h00),
    .rx_tap(rx_tap), .tx_tap(tx_tap), .rx_bypassed(rx_bypassed),
    .tx_bypassed(tx_bypassed), .ctl_pad_skew(ctl_pad_skew),
    .rxd_pad_skew(rxd_pad_skew), .txd_pad_skew(txd_pad_skew),
    .clk_pad_skew(clk_pad_skew));
  rgs_mac_model u_mac (.txc(txc), .tx_ctl(tx_ctl), .txd(txd), .rxc(rxc),
    .rx_ctl(rx_ctl), .rxd(rxd), .cap_ctl(cap_ctl), .cap_d(cap_d));

  // ====================
  // tasks
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one-cycle strobe, then a free edge before the next request
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 cmp({15'h0, reg_rvalid}, 16'h0001);
    d = reg_rdata;
  endtask
  // device, index, data function, then the data access
  task automatic ind(input logic [15:0] ix, input logic w,
                     input logic [15:0] d, output logic [15:0] r);
    wr(5'h0d, 16'h0002);
    wr(5'h0e, ix);
    wr(5'h0d, 16'h4002);
    if (w)
      wr(5'h0e, d);
    rd(5'h0e, r);
  endtask
  task automatic final_report;
    if (num_errors == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ====================
  // main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1 cmp({14'h0, rx_bypassed, tx_bypassed}, 16'h0001);
    // reset bits written 1 then 0, read back as held
    for (int i = 0; i < 9; i++) begin
      ind(rows[i].ix, 1'b0, 16'h0000, q);
      cmp(q, rows[i].pv);
      ind(rows[i].ix, 1'b1, rows[i].wd, q);
      cmp(q, rows[i].ex);
    end
    cmp(txd_pad_skew, 16'habcd);
    cmp(ctl_pad_skew, 16'h00ff);
    cmp(rxd_pad_skew, 16'h1234);
    cmp({14'h0, rx_bypassed, tx_bypassed}, 16'h0002);
    rd(5'h01, q);
    cmp(q, 16'h0000);
    // tuning walks from tap 0x3f down to the measured 0x30
    rx_cal_tap <= 6'h30;
    ind(rgs_pkg::IX_RX_DLL, 1'b1, 16'h0020, q);
    repeat (500) @(posedge clk);
    cmp({10'h0, rx_tap}, 16'h0030);
    ind(rgs_pkg::IX_RX_DLL, 1'b1, 16'h2305, q);
    cmp({10'h0, rx_tap}, 16'h0005);
    ind(rgs_pkg::IX_RX_DLL, 1'b1, 16'h0305, q);
    cmp({10'h0, rx_tap}, 16'h002d);
    // loop reset after the new tap select
    ind(rgs_pkg::IX_DLL_RST, 1'b1, 16'h0001, q);
    cmp({10'h0, rx_tap}, 16'h0002);
    ind(rgs_pkg::IX_DLL_RST, 1'b1, 16'h0000, q);
    ind(rgs_pkg::IX_RX_DLL, 1'b1, 16'h4000, q);
    cmp({8'h0, tx_bypassed, rx_bypassed, rx_tap}, 16'h0040);
    // receive link: status at each speed, idle and frames at 1000 and 100
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      rx_dv <= rxr[i].dv;
      rx_lpi_req <= rxr[i].lp;
      link_up <= rxr[i].lk;
      duplex_full <= rxr[i].dx;
      speed <= rxr[i].sp;
      rx_byte <= rxr[i].b;
      repeat (2) @(posedge rxc);
      @(negedge rxc);
      #5 cmp({6'h0, cap_ctl, cap_d}, rxr[i].e);
    end
    // transmit idle: both nibbles count at 1000, only the first at 100
    @(posedge clk);
    speed <= rgs_pkg::SPD_1000;
    #5 u_mac.send(1'b0, 4'h1, 1'b1, 4'h0);
    repeat (2) @(posedge clk);
    #1 cmp({15'h0, tx_lpi}, 16'h0001);
    u_mac.send(1'b0, 4'h1, 1'b1, 4'h7);
    repeat (2) @(posedge clk);
    #1 cmp({15'h0, tx_lpi}, 16'h0000);
    @(posedge clk);
    speed <= rgs_pkg::SPD_100;
    #5 u_mac.send(1'b0, 4'h1, 1'b1, 4'h7);
    repeat (2) @(posedge clk);
    #1 cmp({15'h0, tx_lpi}, 16'h0001);
    u_mac.send(1'b1, 4'h5, 1'b1, 4'h5);
    repeat (2) @(posedge clk);
    #1 cmp({15'h0, tx_lpi}, 16'h0000);
    // mid-run reset restores the skew mid code and the bypass defaults
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1 cmp(clk_pad_skew, rgs_pkg::RST_CLK_SKEW);
    @(posedge clk);
    #1 cmp({14'h0, rx_bypassed, tx_bypassed}, 16'h0001);
    final_report();
  end
  // watchdog well past the roughly 37 us the run needs
  initial begin
    #200000;
    num_errors++;
    final_report();
  end
endmodule // tb
`default_nettype wire
